// file: banked_data_memory_map_test.sv
// self-checking bench for the banked data memory map
// assumes bdm_map and the execution unit model bdm_core_model
`timescale 1ns/10ps
module banked_data_memory_map_test;
    import bdm_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    bdm_req_s    req;
    bdm_resp_s   resp;
    logic        ready;
    logic [20:0] pc;
    logic [7:0]  working;
    logic [21:0] prog_byte_addr;
    logic        tbl_wr_strobe;
    logic [7:0]  tbl_wr_byte;
    int          n_fail = 0;
    int          n_compared = 0;
    int          seed;
    logic [7:0]  r;
    logic [7:0]  b;
    logic [7:0]  lo;
    logic [7:0]  v;

    always #4 clk = ~clk;

    bdm_map i_bdm_map (.clk(clk), .rst(rst), .req(req), .ready(ready), .resp(resp),
        .pc(pc), .working(working), .prog_byte_addr(prog_byte_addr),
        .tbl_wr_strobe(tbl_wr_strobe), .tbl_wr_byte(tbl_wr_byte));
    bdm_core_model i_bdm_core_model (.clk(clk), .ready(ready), .resp(resp), .req(req));

    // ======================================================
    // expectations and checks
    function automatic logic [7:0] exp_bsr(input logic [7:0] w);
        return {4'h0, w[3:0]};
    endfunction : exp_bsr

    function automatic logic [20:0] exp_add(input logic [20:0] p, input logic [7:0] w);
        return {p[20:8], (p[7:0] + w) & 8'hfe};
    endfunction : exp_add

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t byte got %h want %h", $time, g, e);
        end
    endtask : chk_byte

    task automatic chk_wide(input logic [21:0] g, input logic [21:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t word got %h want %h", $time, g, e);
        end
    endtask : chk_wide

    task automatic op(input bdm_op_e o, input logic acc, input logic [11:0] a,
                      input logic [11:0] d, input logic [7:0] w, input logic [20:0] t);
        int gap;
        gap = $random(seed) & 1;
        i_bdm_core_model.issue(o, acc, a, d, w, t, gap, r);
    endtask : op

    task automatic wr(input logic acc, input logic [11:0] a, input logic [7:0] w);
        op(BDM_OP_WRITE, acc, a, 12'h000, w, 21'h0);
    endtask : wr

    task automatic rd(input logic acc, input logic [11:0] a);
        op(BDM_OP_READ, acc, a, 12'h000, 8'h00, 21'h0);
    endtask : rd

    task automatic end_sim;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // ======================================================
    // scenarios
    initial begin
        seed = 85530;
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk_wide({1'b0, pc}, 22'h0);
        chk_wide(prog_byte_addr, 22'h0);
        // computed jump into a literal table
        op(BDM_OP_CALL, 1'b0, 12'h0, 12'h0, 8'h00, 21'h001230);
        wr(1'b1, ADR_WORKING, 8'h06);
        chk_byte(working, 8'h06);
        op(BDM_OP_ADDW, 1'b1, ADR_PC_LOW, 12'h0, 8'h00, 21'h0);
        chk_wide({1'b0, pc}, {1'b0, exp_add(21'h001230, 8'h06)});
        op(BDM_OP_LITRET, 1'b0, 12'h0, 12'h0, 8'h77, 21'h0);
        chk_byte(r, 8'h77);
        chk_wide({1'b0, pc}, 22'h000002);
        op(BDM_OP_STEP, 1'b0, 12'h0, 12'h0, 8'h00, 21'h0);
        chk_wide({1'b0, pc}, 22'h000004);
        // pc latches
        wr(1'b1, ADR_PC_HIGH_L, 8'h12);
        wr(1'b1, ADR_PC_UPPER_L, 8'h01);
        wr(1'b1, ADR_PC_LOW, 8'h35);
        chk_wide({1'b0, pc}, 22'h011234);
        wr(1'b1, ADR_PC_HIGH_L, 8'h00);
        rd(1'b1, ADR_PC_LOW);
        chk_byte(r, 8'h34);
        rd(1'b1, ADR_PC_HIGH_L);
        chk_byte(r, 8'h12);
        // random banked writes read back through pointer 0
        for (int i = 0; i < 16; i++) begin
            b = $random(seed);
            lo = $random(seed);
            v = $random(seed);
            if (b[3:0] == 4'hf) b[3:0] = 4'he;
            wr(1'b1, ADR_BANK_SELECT, b);
            wr(1'b0, {4'h0, lo}, v);
            rd(1'b1, ADR_BANK_SELECT);
            chk_byte(r, exp_bsr(b));
            wr(1'b1, ADR_PTR0_LOW, lo);
            wr(1'b1, ADR_PTR0_HIGH, {4'h0, b[3:0]});
            rd(1'b1, ADR_OPERAND0);
            chk_byte(r, v);
        end
        // pointer 1 write lands in bank 7
        wr(1'b1, ADR_PTR1_HIGH, 8'h07);
        wr(1'b1, ADR_PTR1_LOW, 8'hab);
        wr(1'b1, ADR_OPERAND1, 8'h5a);
        wr(1'b1, ADR_BANK_SELECT, 8'h07);
        rd(1'b0, 12'h0ab);
        chk_byte(r, 8'h5a);
        rd(1'b1, ADR_PTR1_HIGH);
        chk_byte(r, 8'h07);
        // banked access to an indirect operand still redirects
        wr(1'b1, ADR_PTR0_HIGH, 8'h07);
        wr(1'b1, ADR_PTR0_LOW, 8'hab);
        wr(1'b1, ADR_BANK_SELECT, 8'h0f);
        rd(1'b0, 12'h0ef);
        chk_byte(r, 8'h5a);
        // access bank and move across banks
        wr(1'b1, ADR_BANK_SELECT, 8'h05);
        wr(1'b1, 12'h010, 8'ha5);
        wr(1'b0, 12'h010, 8'h3c);
        rd(1'b1, 12'h010);
        chk_byte(r, 8'ha5);
        op(BDM_OP_MOVE, 1'b0, 12'h510, 12'hf20, 8'h00, 21'h0);
        chk_byte(r, 8'h3c);
        chk_byte({7'h0, ready}, 8'h00);
        wr(1'b1, ADR_PTR2_HIGH, 8'h0f);
        wr(1'b1, ADR_PTR2_LOW, 8'h20);
        rd(1'b1, ADR_OPERAND2);
        chk_byte(r, 8'h3c);
        // unimplemented places read zero
        wr(1'b1, 12'h060, 8'hff);
        rd(1'b1, 12'h060);
        chk_byte(r, 8'h00);
        rd(1'b1, 12'h0d4);
        chk_byte(r, 8'h00);
        // table pointer and latch
        wr(1'b1, ADR_TBL_LOW, 8'h35);
        wr(1'b1, ADR_TBL_HIGH, 8'hc2);
        wr(1'b1, ADR_TBL_UPPER, 8'h2a);
        chk_wide(prog_byte_addr, 22'h2ac235);
        wr(1'b1, ADR_TBL_LATCH, 8'h9e);
        op(BDM_OP_TBLWR, 1'b0, 12'h0, 12'h0, 8'h00, 21'h0);
        chk_byte({7'h0, tbl_wr_strobe}, 8'h01);
        chk_byte(tbl_wr_byte, 8'h9e);
        op(BDM_OP_TBLRD, 1'b0, 12'h0, 12'h0, 8'h61, 21'h0);
        chk_byte({7'h0, tbl_wr_strobe}, 8'h00);
        rd(1'b1, ADR_TBL_LATCH);
        chk_byte(r, 8'h61);
        // general ram survives a reset
        wr(1'b1, ADR_BANK_SELECT, 8'h01);
        wr(1'b0, 12'h023, 8'h99);
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(1'b1, ADR_BANK_SELECT);
        chk_byte(r, 8'h00);
        wr(1'b1, ADR_BANK_SELECT, 8'h01);
        rd(1'b0, 12'h023);
        chk_byte(r, 8'h99);
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end
endmodule : banked_data_memory_map_test

// file: bdm_core_model.sv
// execution unit model: issues one request at a time to the map
// assumes ready and resp come from bdm_map on the same clk
`timescale 1ns/10ps
module bdm_core_model (
    input  wire logic               clk,
    input  wire logic               ready,
    input  wire bdm_pkg::bdm_resp_s resp,
    output bdm_pkg::bdm_req_s       req
);
    import bdm_pkg::*;

    // ======================================================
    // request driver
    initial req = '0;

    // waits out ready low, holds the request over one edge, then idles
    task automatic issue(input bdm_op_e op, input logic acc, input logic [11:0] a,
                         input logic [11:0] d, input logic [7:0] v,
                         input logic [20:0] t, input int gap, output logic [7:0] rv);
        int n;
        n = 0;
        repeat (gap) @(negedge clk);
        @(negedge clk);
        while (ready !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        req = '{op: op, access: acc, addr: a, dst: d, data: v, target: t};
        @(negedge clk);
        rv = (resp.valid === 1'b1) ? resp.data : 8'hxx;
        req = '0;
    endtask : issue
endmodule : bdm_core_model

// file: bdm_map.sv
// banked data memory map with core registers, pc and table pointer
// assumes the execution unit issues one request per clk on the same clock
`timescale 1ns/10ps
module bdm_map #(
    parameter int GPR_BYTES   = 3936,
    parameter int STACK_DEPTH = 31
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire bdm_pkg::bdm_req_s req,
    output logic                   ready,
    output bdm_pkg::bdm_resp_s     resp,
    output logic [20:0]            pc,
    output logic [7:0]             working,
    output logic [21:0]            prog_byte_addr,
    output logic                   tbl_wr_strobe,
    output logic [7:0]             tbl_wr_byte
);
    import bdm_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH + 1);

    // ======================================================
    // address decode helpers
    function automatic logic [11:0] bdm_direct(input logic acc, input logic [7:0] fa,
                                               input logic [3:0] bank);
        if (acc) begin
            return (fa < ACCESS_SPLIT) ? {4'h0, fa} : {4'hf, fa};
        end
        return {bank, fa};
    endfunction : bdm_direct

    function automatic logic [11:0] bdm_redirect(input logic [11:0] a, input logic [11:0] f0,
                                                 input logic [11:0] f1, input logic [11:0] f2);
        case (a)
            ADR_OPERAND0: return f0;
            ADR_OPERAND1: return f1;
            ADR_OPERAND2: return f2;
            default:      return a;
        endcase
    endfunction : bdm_redirect

    function automatic logic bdm_in_gpr(input logic [11:0] a);
        return (a < SFR_BASE) && (32'(a) < GPR_BYTES);
    endfunction : bdm_in_gpr

    // ======================================================
    // state
    logic [7:0]      gpr_mem [GPR_BYTES];
    logic [20:0]     stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_reg;
    logic [3:0]      bank_reg;
    logic [11:0]     fsr0_reg, fsr1_reg, fsr2_reg;
    logic [7:0]      working_register_reg, program_table_latch_reg, pc_high_latch_reg;
    logic [4:0]      pc_upper_latch_reg;
    logic [21:0]     program_table_pointer_reg;
    logic [20:0]     pc_reg, pc_next;
    logic            mv_busy_reg;
    logic [11:0]     mv_dst_reg;
    logic [7:0]      mv_data_reg;
    logic            rvalid_reg, tbl_wr_reg;
    logic [7:0]      rdata_reg, tbl_byte_reg;

    // ======================================================
    // request decode
    wire accept   = !mv_busy_reg && (req.op != BDM_OP_NONE);
    wire op_move  = accept && (req.op == BDM_OP_MOVE);
    wire op_addw  = accept && (req.op == BDM_OP_ADDW);
    wire op_wr    = accept && (req.op == BDM_OP_WRITE);
    wire op_lit   = accept && (req.op == BDM_OP_LITRET);
    wire op_call  = accept && (req.op == BDM_OP_CALL);
    wire op_step  = accept && (req.op == BDM_OP_STEP);
    wire op_tblrd = accept && (req.op == BDM_OP_TBLRD);
    wire op_tblwr = accept && (req.op == BDM_OP_TBLWR);
    wire op_reads = accept && (req.op == BDM_OP_READ || req.op == BDM_OP_ADDW
                               || req.op == BDM_OP_MOVE);
    wire [11:0] src_raw = (req.op == BDM_OP_MOVE) ? req.addr
                        : bdm_direct(req.access, req.addr[7:0], bank_reg);
    wire [11:0] rd_addr = bdm_redirect(src_raw, fsr0_reg, fsr1_reg, fsr2_reg);
    wire [11:0] mv_dst  = bdm_redirect(req.dst, fsr0_reg, fsr1_reg, fsr2_reg);
    wire        rd_gpr  = bdm_in_gpr(rd_addr);
    wire        rd_pcl  = op_reads && (rd_addr == ADR_PC_LOW);

    // ======================================================
    // read mux
    logic [7:0] sfr_val;
    logic       sfr_hit;
    always_comb begin
        sfr_hit = 1'b1;
        case (rd_addr)
            ADR_PTR0_LOW:    sfr_val = fsr0_reg[7:0];
            ADR_PTR0_HIGH:   sfr_val = {4'h0, fsr0_reg[11:8]};
            ADR_PTR1_LOW:    sfr_val = fsr1_reg[7:0];
            ADR_PTR1_HIGH:   sfr_val = {4'h0, fsr1_reg[11:8]};
            ADR_PTR2_LOW:    sfr_val = fsr2_reg[7:0];
            ADR_PTR2_HIGH:   sfr_val = {4'h0, fsr2_reg[11:8]};
            ADR_BANK_SELECT: sfr_val = {4'h0, bank_reg};
            ADR_WORKING:     sfr_val = working_register_reg;
            ADR_TBL_LATCH:   sfr_val = program_table_latch_reg;
            ADR_TBL_LOW:     sfr_val = program_table_pointer_reg[7:0];
            ADR_TBL_HIGH:    sfr_val = program_table_pointer_reg[15:8];
            ADR_TBL_UPPER:   sfr_val = {2'b00, program_table_pointer_reg[21:16]};
            ADR_PC_LOW:      sfr_val = pc_reg[7:0];
            ADR_PC_HIGH_L:   sfr_val = pc_high_latch_reg;
            ADR_PC_UPPER_L:  sfr_val = {3'b000, pc_upper_latch_reg};
            default: begin
                sfr_val = 8'h00;
                sfr_hit = 1'b0;
            end
        endcase
    end
    wire [7:0] rd_val = rd_gpr ? gpr_mem[rd_addr] : sfr_val;

    // ======================================================
    // unified write port
    wire        wr_en   = mv_busy_reg || op_wr || op_addw;
    wire [11:0] wr_addr = mv_busy_reg ? mv_dst_reg : rd_addr;
    wire [7:0]  wr_data = mv_busy_reg ? mv_data_reg
                        : (op_addw ? 8'(rd_val + working_register_reg) : req.data);
    wire        wr_gpr  = wr_en && bdm_in_gpr(wr_addr);
    wire        wr_pcl  = wr_en && (wr_addr == ADR_PC_LOW);
    wire [4:0]  up_src  = rd_pcl ? pc_reg[20:16] : pc_upper_latch_reg;
    wire [7:0]  hi_src  = rd_pcl ? pc_reg[15:8] : pc_high_latch_reg;
    wire [SP_W-1:0] sp_top = sp_reg - SP_W'(1);

    // ======================================================
    // program counter
    always_comb begin
        pc_next = pc_reg;
        if (wr_pcl) begin
            pc_next = {up_src, hi_src, wr_data[7:1], 1'b0};
        end else if (op_lit && sp_reg != '0) begin
            pc_next = stack_mem[sp_top];
        end else if (op_call) begin
            pc_next = {req.target[20:1], 1'b0};
        end else if (op_step) begin
            pc_next = pc_reg + PC_STEP;
        end
    end

    // ======================================================
    // general ram, never reset
    always_ff @(posedge clk) begin
        if (wr_gpr) begin
            gpr_mem[wr_addr] <= wr_data;
        end
    end

    // ======================================================
    // return stack
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_reg <= '0;
        end else if (op_call && 32'(sp_reg) < STACK_DEPTH) begin
            stack_mem[sp_reg] <= pc_reg + PC_STEP;
            sp_reg            <= sp_reg + SP_W'(1);
        end else if (op_lit && sp_reg != '0) begin
            sp_reg <= sp_top;
        end
    end

    // ======================================================
    // core registers
    always_ff @(posedge clk) begin
        if (rst) begin
            bank_reg   <= RST_BANK;
            fsr0_reg   <= RST_PTR;
            fsr1_reg   <= RST_PTR;
            fsr2_reg   <= RST_PTR;
            working_register_reg   <= RST_BYTE;
            program_table_latch_reg <= RST_BYTE;
            pc_high_latch_reg <= RST_BYTE;
            pc_upper_latch_reg <= RST_BYTE[4:0];
            program_table_pointer_reg <= RST_PROGRAM_TABLE_POINTER;
            pc_reg     <= RST_PC;
        end else begin
            pc_reg <= pc_next;
            if (rd_pcl) begin
                pc_high_latch_reg <= pc_reg[15:8];
                pc_upper_latch_reg <= pc_reg[20:16];
            end
            if (accept && req.op == BDM_OP_TBLRD) begin
                program_table_latch_reg <= req.data;
            end
            if (wr_en) begin
                case (wr_addr)
                    ADR_PTR0_LOW:    fsr0_reg[7:0]      <= wr_data;
                    ADR_PTR0_HIGH:   fsr0_reg[11:8]     <= wr_data[3:0];
                    ADR_PTR1_LOW:    fsr1_reg[7:0]      <= wr_data;
                    ADR_PTR1_HIGH:   fsr1_reg[11:8]     <= wr_data[3:0];
                    ADR_PTR2_LOW:    fsr2_reg[7:0]      <= wr_data;
                    ADR_PTR2_HIGH:   fsr2_reg[11:8]     <= wr_data[3:0];
                    ADR_BANK_SELECT: bank_reg           <= wr_data[3:0];
                    ADR_WORKING:     working_register_reg           <= wr_data;
                    ADR_TBL_LATCH:   program_table_latch_reg         <= wr_data;
                    ADR_TBL_LOW:     program_table_pointer_reg[7:0]    <= wr_data;
                    ADR_TBL_HIGH:    program_table_pointer_reg[15:8]   <= wr_data;
                    ADR_TBL_UPPER:   program_table_pointer_reg[21:16]  <= wr_data[5:0];
                    ADR_PC_HIGH_L:   pc_high_latch_reg         <= wr_data;
                    ADR_PC_UPPER_L:  pc_upper_latch_reg         <= wr_data[4:0];
                    default: ;
                endcase
            end
        end
    end

    // ======================================================
    // file to file move sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            mv_busy_reg <= 1'b0;
            mv_dst_reg  <= RST_PTR;
            mv_data_reg <= RST_BYTE;
        end else begin
            mv_busy_reg <= op_move;
            if (op_move) begin
                mv_dst_reg  <= mv_dst;
                mv_data_reg <= rd_val;
            end
        end
    end

    // ======================================================
    // answers and table strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_reg   <= 1'b0;
            rdata_reg    <= RST_BYTE;
            tbl_wr_reg   <= 1'b0;
            tbl_byte_reg <= RST_BYTE;
        end else begin
            rvalid_reg <= op_reads || op_lit;
            rdata_reg  <= op_lit ? req.data : rd_val;
            tbl_wr_reg <= accept && req.op == BDM_OP_TBLWR;
            if (accept && req.op == BDM_OP_TBLWR) begin
                tbl_byte_reg <= program_table_latch_reg;
            end
        end
    end

    assign ready          = !mv_busy_reg;
    assign resp.valid     = rvalid_reg;
    assign resp.data      = rdata_reg;
    assign pc             = pc_reg;
    assign working        = working_register_reg;
    assign prog_byte_addr = program_table_pointer_reg;
    assign tbl_wr_strobe  = tbl_wr_reg;
    assign tbl_wr_byte    = tbl_byte_reg;

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_move_start;
        op_move;
    endsequence
    sequence s_move_write;
        mv_busy_reg && wr_en && !ready;
    endsequence

    chk_bank_upper_zero: assert property (rvalid_reg && $past(op_reads)
        && $past(rd_addr) == ADR_BANK_SELECT |-> rdata_reg[7:4] == 4'h0)
        else $error("bank select upper nibble not zero");

    chk_bank_readback: assert property (op_reads && rd_addr == ADR_BANK_SELECT
        |=> rdata_reg == {4'h0, $past(bank_reg)})
        else $error("bank select read back wrong");

    chk_bank_store: assert property (wr_en && wr_addr == ADR_BANK_SELECT
        |=> bank_reg == $past(wr_data[3:0]))
        else $error("bank select low nibble not stored");

    chk_pc_word_align: assert property (pc_reg[0] == 1'b0)
        else $error("pc low bit set");

    chk_step_by_two: assert property (op_step |=> pc_reg == $past(pc_reg) + PC_STEP)
        else $error("pc did not step by two");

    chk_pc_hold: assert property (!wr_pcl && !op_lit && !op_call && !op_step
        |=> pc_reg == $past(pc_reg))
        else $error("pc changed without a cause");

    chk_unimpl_zero: assert property (op_reads && !rd_gpr && !sfr_hit
        |=> rdata_reg == 8'h00)
        else $error("unimplemented location read nonzero");

    chk_pcl_load: assert property (wr_pcl && !rd_pcl
        |=> pc_reg[20:8] == {$past(pc_upper_latch_reg), $past(pc_high_latch_reg)})
        else $error("pc upper not loaded from latches");

    chk_pcl_latch_copy: assert property (rd_pcl
        |=> {pc_upper_latch_reg, pc_high_latch_reg} == $past(pc_reg[20:8]))
        else $error("pc latches not refreshed on read");

    chk_addw_jump: assert property (op_addw && rd_addr == ADR_PC_LOW
        |=> pc_reg[7:0] == (($past(pc_reg[7:0]) + $past(working_register_reg)) & 8'hfe)
        && pc_reg[20:8] == $past(pc_reg[20:8]))
        else $error("computed jump landed wrong");

    chk_call_push: assert property (op_call && 32'(sp_reg) < STACK_DEPTH
        |=> sp_reg == $past(sp_reg) + SP_W'(1)
        && pc_reg == {$past(req.target[20:1]), 1'b0})
        else $error("call did not push");

    chk_move_two_cycle: assert property (s_move_start |=> s_move_write ##1 ready)
        else $error("move did not finish in two cycles");

    chk_move_data: assert property (s_move_start
        |=> rvalid_reg && rdata_reg == mv_data_reg)
        else $error("move source byte not answered");

    chk_litret_pop: assert property (op_lit && sp_reg != '0
        |=> rvalid_reg && rdata_reg == $past(req.data) && sp_reg == $past(sp_top))
        else $error("literal return did not pop");

    chk_indirect_path: assert property (accept && req.op == BDM_OP_READ && !req.access
        && {bank_reg, req.addr[7:0]} == ADR_OPERAND0 |-> rd_addr == fsr0_reg)
        else $error("indirect operand not redirected");

    chk_indirect_write: assert property (op_wr && src_raw == ADR_OPERAND1
        |-> wr_addr == fsr1_reg)
        else $error("indirect write not redirected");

    chk_access_bank: assert property (accept && req.op == BDM_OP_READ && req.access
        && req.addr[7:0] < ACCESS_SPLIT |-> src_raw[11:8] == 4'h0)
        else $error("access bank low segment wrong");

    chk_banked_addr: assert property (accept && req.op == BDM_OP_WRITE && !req.access
        |-> src_raw == {bank_reg, req.addr[7:0]})
        else $error("banked address wrong");

    chk_table_latch: assert property (op_tblrd
        |=> program_table_latch_reg == $past(req.data))
        else $error("table latch not loaded");

    chk_table_strobe: assert property (op_tblwr
        |=> tbl_wr_strobe && tbl_wr_byte == $past(program_table_latch_reg))
        else $error("table write strobe wrong");

    chk_program_table_pointer_byte: assert property (wr_en && wr_addr == ADR_TBL_LOW
        |=> prog_byte_addr[7:0] == $past(wr_data))
        else $error("table pointer low byte not stored");
endmodule : bdm_map

// file: bdm_pkg.sv
// banked data memory map: constants, operation codes and carriers
// assumes one core clock shared by the execution unit and this block
//
// Behaviour
// - adding working register into pc low byte advances the program counter
// - literal return pops the return stack and hands back its literal byte
// - table pointer holds a byte address; table latch moves one byte
// - table pointer bit zero picks one of two bytes in a word
// - data addresses are twelve bits wide, up to 4096 bytes
// - banked access takes bank select low nibble over the instruction byte
// - only bank select bits three to zero are stored
// - f60h to fffh are special registers; everything below is general ram
// - unimplemented locations read as zero
// - indirect pointers hold full addresses and bypass bank select
// - file to file move takes two cycles across any banks
// - access bank reaches low bank 0 and high bank 15 ignoring bank select
// - general ram is never cleared by reset
// - indirect operand addresses have no storage and redirect
// - pc low write loads upper pc from latches, but addw on pc low keeps current upper pc; read refreshes latches
// - pc low bit zero stays zero so pc steps by two
package bdm_pkg;
    // ======================================================
    // address map
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] SFR_BASE        = 12'hf60;
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
    localparam logic [11:0] ADR_PTR2_LOW    = 12'hfd9;
    localparam logic [11:0] ADR_PTR2_HIGH   = 12'hfda;
    localparam logic [11:0] ADR_OPERAND2    = 12'hfdf;
    localparam logic [11:0] ADR_BANK_SELECT = 12'hfe0;
    localparam logic [11:0] ADR_PTR1_LOW    = 12'hfe1;
    localparam logic [11:0] ADR_PTR1_HIGH   = 12'hfe2;
    localparam logic [11:0] ADR_OPERAND1    = 12'hfe7;
    localparam logic [11:0] ADR_WORKING     = 12'hfe8;
    localparam logic [11:0] ADR_PTR0_LOW    = 12'hfe9;
    localparam logic [11:0] ADR_PTR0_HIGH   = 12'hfea;
    localparam logic [11:0] ADR_OPERAND0    = 12'hfef;
    localparam logic [11:0] ADR_TBL_LATCH   = 12'hff5;
    localparam logic [11:0] ADR_TBL_LOW     = 12'hff6;
    localparam logic [11:0] ADR_TBL_HIGH    = 12'hff7;
    localparam logic [11:0] ADR_TBL_UPPER   = 12'hff8;
    localparam logic [11:0] ADR_PC_LOW      = 12'hff9;
    localparam logic [11:0] ADR_PC_HIGH_L   = 12'hffa;
    localparam logic [11:0] ADR_PC_UPPER_L  = 12'hffb;
    // ======================================================
    // reset values and steps
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [3:0]  RST_BANK        = 4'h0;
    localparam logic [11:0] RST_PTR         = 12'h000;
    localparam logic [20:0] RST_PC          = 21'h000000;
    localparam logic [21:0] RST_PROGRAM_TABLE_POINTER      = 22'h000000;
    localparam logic [20:0] PC_STEP         = 21'h000002;
    // ======================================================
    // operations and carriers
    typedef enum logic [3:0] {
        BDM_OP_NONE, BDM_OP_READ, BDM_OP_WRITE, BDM_OP_ADDW, BDM_OP_MOVE,
        BDM_OP_LITRET, BDM_OP_CALL, BDM_OP_STEP, BDM_OP_TBLRD, BDM_OP_TBLWR
    } bdm_op_e;

    typedef struct packed {
        bdm_op_e     op;
        logic        access;
        logic [11:0] addr;
        logic [11:0] dst;
        logic [7:0]  data;
        logic [20:0] target;
    } bdm_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bdm_resp_s;
endpackage : bdm_pkg
